// ===== sync_sram_defines.vh
// Constants for the flow-through synchronous SRAM control block.
// Assumes a single 125 MHz clock and an includer that owns the storage array.
//
// Function
// - Selected only when select_low_a low, select_high high, select_low_b low.
// - Full-width write on full-word write low, or gate low with all lanes low.
// - After a write, data outputs stay high impedance until a new read strobe.
// - Data outputs are high impedance when the device leaves sleep.
// - Sleep request high enters sleep; stored contents are kept unchanged.
// - Processor strobe starts a read whenever selected; writes follow later or with controller strobe.
// - With gate low, each lane whose write input is low writes its byte and parity.
// - Output enable is ignored in writes; outputs off when inactive or after a strobe while deselected.
`ifndef SYNC_SRAM_DEFINES_VH
`define SYNC_SRAM_DEFINES_VH
`define SRAM_ADDR_W 17
`define SRAM_DEPTH 131072
`define SRAM_DATA_W 36
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define BURST_W 2
`define ST_IDLE 2'h0
`define ST_READ 2'h1
`define ST_WRITE 2'h2
`define ST_SLEEP 2'h3
`endif

// ===== sync_sram_select_write_sleep.v
// Flow-through synchronous SRAM core: selects, writes, bus turnaround, sleep.
// Assumes raw pin inputs from outside this clock domain; each passes two flops here.
`timescale 1ns/1ns
`include "sync_sram_defines.vh"
module sync_sram_select_write_sleep (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_chip_select_low_a_n,
  input wire i_chip_select_high,
  input wire i_chip_select_low_b_n,
  input wire i_processor_addr_strobe_n,
  input wire i_controller_addr_strobe_n,
  input wire i_advance_n,
  input wire i_full_word_write_n,
  input wire i_byte_write_gate_n,
  input wire [`SRAM_LANES-1:0] i_lane_write_n,
  input wire i_output_enable_n,
  input wire i_sleep_request,
  input wire [`SRAM_ADDR_W-1:0] i_addr,
  input wire [`SRAM_DATA_W-1:0] i_data,
  output reg [`SRAM_DATA_W-1:0] o_data,
  output reg [`SRAM_DATA_W-1:0] o_data_oe,
  output reg o_sleeping
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling
  // Every pin costs two cycles of latency; traded for metastability safety
  reg s1_cs_a_n;
  reg s2_cs_a_n;
  reg s1_cs_h;
  reg s2_cs_h;
  reg s1_cs_b_n;
  reg s2_cs_b_n;
  reg s1_pstrb_n;
  reg s2_pstrb_n;
  reg s1_cstrb_n;
  reg s2_cstrb_n;
  reg s1_adv_n;
  reg s2_adv_n;
  reg s1_fullw_n;
  reg s2_fullw_n;
  reg s1_gate_n;
  reg s2_gate_n;
  reg s1_oe_n;
  reg s2_oe_n;
  reg s1_sleep;
  reg s2_sleep;
  reg [`SRAM_LANES-1:0] s1_lane_n;
  reg [`SRAM_LANES-1:0] s2_lane_n;
  reg [`SRAM_ADDR_W-1:0] s1_addr;
  reg [`SRAM_ADDR_W-1:0] s2_addr;
  reg [`SRAM_DATA_W-1:0] s1_data;
  reg [`SRAM_DATA_W-1:0] s2_data;

  // Two stages per pin; first stage only feeds the second
  // Reset values equal the idle pin levels, so no false strobe follows reset
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_cs_a_n <= 1'h1;
      s2_cs_a_n <= 1'h1;
      s1_cs_h <= 1'h0;
      s2_cs_h <= 1'h0;
      s1_cs_b_n <= 1'h1;
      s2_cs_b_n <= 1'h1;
      s1_pstrb_n <= 1'h1;
      s2_pstrb_n <= 1'h1;
      s1_cstrb_n <= 1'h1;
      s2_cstrb_n <= 1'h1;
      s1_adv_n <= 1'h1;
      s2_adv_n <= 1'h1;
      s1_fullw_n <= 1'h1;
      s2_fullw_n <= 1'h1;
      s1_gate_n <= 1'h1;
      s2_gate_n <= 1'h1;
      s1_oe_n <= 1'h1;
      s2_oe_n <= 1'h1;
      s1_sleep <= 1'h0;
      s2_sleep <= 1'h0;
      s1_lane_n <= 4'hF;
      s2_lane_n <= 4'hF;
      s1_addr <= 17'h0;
      s2_addr <= 17'h0;
      s1_data <= 36'h0;
      s2_data <= 36'h0;
    end else begin
      s1_cs_a_n <= i_chip_select_low_a_n;
      s2_cs_a_n <= s1_cs_a_n;
      s1_cs_h <= i_chip_select_high;
      s2_cs_h <= s1_cs_h;
      s1_cs_b_n <= i_chip_select_low_b_n;
      s2_cs_b_n <= s1_cs_b_n;
      s1_pstrb_n <= i_processor_addr_strobe_n;
      s2_pstrb_n <= s1_pstrb_n;
      s1_cstrb_n <= i_controller_addr_strobe_n;
      s2_cstrb_n <= s1_cstrb_n;
      s1_adv_n <= i_advance_n;
      s2_adv_n <= s1_adv_n;
      s1_fullw_n <= i_full_word_write_n;
      s2_fullw_n <= s1_fullw_n;
      s1_gate_n <= i_byte_write_gate_n;
      s2_gate_n <= s1_gate_n;
      s1_lane_n <= i_lane_write_n;
      s2_lane_n <= s1_lane_n;
      s1_oe_n <= i_output_enable_n;
      s2_oe_n <= s1_oe_n;
      s1_sleep <= i_sleep_request;
      s2_sleep <= s1_sleep;
      s1_addr <= i_addr;
      s2_addr <= s1_addr;
      s1_data <= i_data;
      s2_data <= s1_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  // Any single select out of place deselects the part
  function sel_decode;
    input a_n, h, b_n;
    begin
      sel_decode = !a_n && h && !b_n;
    end
  endfunction

  // Per-lane write mask; global write overrides all lanes
  function [`SRAM_LANES-1:0] lane_mask;
    input fullw_n, gate_n;
    input [`SRAM_LANES-1:0] lanes_n;
    begin
      if (!fullw_n)
        lane_mask = 4'hF;
      else if (!gate_n)
        lane_mask = ~lanes_n;
      else
        lane_mask = 4'h0;
    end
  endfunction

  wire selected = sel_decode(s2_cs_a_n, s2_cs_h, s2_cs_b_n);
  wire [`SRAM_LANES-1:0] wmask = lane_mask(s2_fullw_n, s2_gate_n, s2_lane_n);
  wire pstrb = !s2_pstrb_n;
  wire cstrb = !s2_cstrb_n;
  wire adv = !s2_adv_n;

  ////////////////////////////////////////////////////////////////////////////
  // Access state
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`SRAM_ADDR_W-1:0] base_addr;
  reg [`BURST_W-1:0] burst;
  reg [`SRAM_DATA_W-1:0] mem [0:`SRAM_DEPTH-1];
  wire [`SRAM_ADDR_W-1:0] cur_addr = {base_addr[`SRAM_ADDR_W-1:`BURST_W], burst};
  // Processor strobe is honoured only when selected; controller strobe too
  wire start = (pstrb || cstrb) && selected;

  // Next state; sleep has top priority and blocks all access
  always @* begin
    next_state = state;
    case (state)
      `ST_SLEEP: if (!s2_sleep) next_state = `ST_IDLE;
      default: begin
        if (s2_sleep)
          next_state = `ST_SLEEP;
        else if (pstrb)
          next_state = selected ? `ST_READ : `ST_IDLE;
        else if (cstrb)
          next_state = !selected ? `ST_IDLE : ((wmask != 4'h0) ? `ST_WRITE : `ST_READ);
        else if (state != `ST_IDLE && wmask != 4'h0)
          next_state = `ST_WRITE; // write on a later clock
        else if (state == `ST_WRITE)
          next_state = `ST_WRITE; // bus stays off until a new read
      end
    endcase
  end

  // State, address capture and burst counter
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= `ST_IDLE;
      base_addr <= 17'h0;
      burst <= 2'h0;
      o_sleeping <= 1'h0;
    end else begin
      state <= next_state;
      o_sleeping <= (next_state == `ST_SLEEP);
      if (next_state != `ST_SLEEP && start && !(pstrb && !selected)) begin
        base_addr <= s2_addr;
        burst <= s2_addr[`BURST_W-1:0];
      end else if (state != `ST_SLEEP && adv && state != `ST_IDLE) begin
        burst <= burst + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage: lane writes; no write reaches the array in sleep
  wire [`SRAM_ADDR_W-1:0] waddr = start ? s2_addr : cur_addr;
  wire do_write = (next_state == `ST_WRITE) && (wmask != 4'h0);
  genvar g;
  generate
    for (g = 0; g < `SRAM_LANES; g = g + 1) begin : g_lane
      // Byte plus its parity bit share one lane strobe
      always @(posedge i_sys_clk) begin
        if (do_write && wmask[g])
          mem[waddr][g*`SRAM_LANE_W +: `SRAM_LANE_W] <= s2_data[g*`SRAM_LANE_W +: `SRAM_LANE_W];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output drive: output enable gated off outside reads
  wire rd_on = (state == `ST_READ) && !s2_oe_n;

  // Registered outputs; enable width matches data for per-bit pad control
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data <= 36'h0;
      o_data_oe <= 36'h0;
    end else begin
      o_data <= mem[cur_addr];
      o_data_oe <= (rd_on && next_state == `ST_READ) ? {`SRAM_DATA_W{1'b1}} : 36'h0;
    end
  end

endmodule // sync_sram_select_write_sleep

// ===== sram_checker_assertions.sv
// Checker for the SRAM control block, bound to its ports.
// Assumes controls act two to four cycles after the pins.
`timescale 1ns/1ns
`include "sync_sram_defines.vh"
module sram_checker (
  input wire i_sys_clk,
  input wire i_rstn,
  input wire i_chip_select_low_a_n,
  input wire i_chip_select_high,
  input wire i_chip_select_low_b_n,
  input wire i_processor_addr_strobe_n,
  input wire i_controller_addr_strobe_n,
  input wire i_full_word_write_n,
  input wire i_byte_write_gate_n,
  input wire [`SRAM_LANES-1:0] i_lane_write_n,
  input wire i_output_enable_n,
  input wire i_sleep_request,
  input wire [`SRAM_DATA_W-1:0] o_data_oe,
  input wire o_sleeping
);
  logic [7:0] hist;
  wire sel = !i_chip_select_low_a_n && i_chip_select_high && !i_chip_select_low_b_n;
  wire nowr = i_full_word_write_n && (i_byte_write_gate_n || &i_lane_write_n);
  wire rd = sel && (!i_processor_addr_strobe_n || (!i_controller_addr_strobe_n && nowr));
  wire wr = sel && i_processor_addr_strobe_n && !i_controller_addr_strobe_n && !nowr;
  wire on = &o_data_oe;
  wire off = ~|o_data_oe;
  // Recent reads, so a bus turn-on can be traced to its cause
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) hist <= 8'h00;
    else hist <= {hist[6:0], rd};
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_cause; $rose(on) |-> |hist; endproperty
  a_cause: assert property (p_cause) else $error("bus on without read");
  property p_read; rd && !i_output_enable_n && !i_sleep_request |-> ##[2:6] on; endproperty
  a_read: assert property (p_read) else $error("read gave no data");
  property p_wroff; wr |-> ##[1:6] off; endproperty
  a_wroff: assert property (p_wroff) else $error("bus on after write");
  property p_oeoff; i_output_enable_n [*6] |-> off; endproperty
  a_oeoff: assert property (p_oeoff) else $error("bus on with enable off");
  property p_sleep; i_sleep_request [*6] |-> o_sleeping; endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_wake; !i_sleep_request [*6] |-> !o_sleeping; endproperty
  a_wake: assert property (p_wake) else $error("stuck in sleep");
  property p_sleepoff; o_sleeping |-> off; endproperty
  a_sleepoff: assert property (p_sleepoff) else $error("bus on in sleep");
  property p_exit; $fell(o_sleeping) |-> off; endproperty
  a_exit: assert property (p_exit) else $error("bus on at wake");
  cover property (rd ##[2:6] on);
  cover property (wr);
  cover property ($fell(o_sleeping));
endmodule // sram_checker
bind sync_sram_select_write_sleep sram_checker u_sram_checker (.*);

// ===== sram_host.sv
// Processor-side model that drives the SRAM pins.
// Assumes the bench calls cyc; pins move at falling edges only.
`timescale 1ns/1ns
module sram_host (
  input wire clk,
  output logic [2:0] sel,
  output logic ps_n,
  output logic cs_n,
  output logic fullw_n,
  output logic gate_n,
  output logic [3:0] lane_n,
  output logic oe_n,
  output logic slp,
  output logic [16:0] addr,
  output logic [35:0] data
);
  // Idle, deselected, sleep held low from time zero
  initial begin
    {sel, ps_n, cs_n, fullw_n, gate_n, lane_n, oe_n, slp} = 13'h1FFC;
    addr = 17'h00000;
    data = 36'h000000000;
  end
  // One strobed cycle, then deselect so sleep entry is always legal
  task cyc(input logic [2:0] s, input logic p, input logic c, input logic g,
           input logic [3:0] l, input logic [16:0] a, input logic [35:0] d);
    @(negedge clk);
    {sel, ps_n, cs_n, fullw_n, gate_n, lane_n} = {s, p, c, g, 1'b0, l};
    addr = a;
    data = d;
    @(negedge clk);
    {sel, ps_n, cs_n, fullw_n, gate_n, lane_n} = 11'h7FF;
    addr = ~a;
    data = ~d; // Released bus shows no stale value
  endtask
endmodule // sram_host

// ===== test_sync_sram_select_write_sleep.sv
// Bench: random lane writes and reads against a word model.
// Assumes the host model drives all pins except advance, which the bench ties high; checker bound in.
`timescale 1ns/1ns
module test_sync_sram_select_write_sleep;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] sel;
  logic ps_n, cs_n, fullw_n, gate_n, oe_n, slp, o_sleeping;
  logic [3:0] lane_n;
  logic [16:0] addr;
  logic [35:0] data, o_data, o_data_oe, d;
  logic [35:0] mem [4];
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  sram_host u_sram_host (.clk(i_sys_clk), .sel, .ps_n, .cs_n, .fullw_n, .gate_n, .lane_n, .oe_n, .slp, .addr, .data);
  sync_sram_select_write_sleep u_sync_sram_select_write_sleep (.i_sys_clk, .i_rstn,
    .i_chip_select_low_a_n(sel[2]), .i_chip_select_high(sel[1]), .i_chip_select_low_b_n(sel[0]),
    .i_processor_addr_strobe_n(ps_n), .i_controller_addr_strobe_n(cs_n), .i_advance_n(1'b1),
    .i_full_word_write_n(fullw_n), .i_byte_write_gate_n(gate_n), .i_lane_write_n(lane_n),
    .i_output_enable_n(oe_n), .i_sleep_request(slp), .i_addr(addr), .i_data(data),
    .o_data, .o_data_oe, .o_sleeping);
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Write, then update the lanes whose write input was low, or all lanes on a full-word write
  task wr(input int a, input logic g, input logic [3:0] l);
    d = {$urandom(), 4'($urandom())};
    u_sram_host.cyc(3'h2, 1'b1, 1'b0, g, l, 17'(a), d);
    for (int k = 0; k < 4; k++)
      if (!g || !l[k]) mem[a][9*k +: 9] = d[9*k +: 9];
  endtask
  // Read by either strobe; masking with the enable catches a silent bus
  task rd(input int a, input logic p);
    int n;
    n = 0;
    u_sram_host.cyc(3'h2, p, !p, 1'b1, 4'hF, 17'(a), 36'h0);
    while (o_data_oe !== 36'hFFFFFFFFF && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(o_data & o_data_oe, mem[a]);
  endtask
  initial begin
    void'($urandom(64));
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_rstn = 1'b1;
    for (int i = 0; i < 4; i++) wr(i, 1'b0, 4'hF);
    for (int i = 0; i < 16; i++) begin
      wr(i % 4, i[0], 4'($urandom() % 15));
      rd(i % 4, i[1]);
    end
    wr(1, 1'b0, 4'hF);
    repeat (6) @(negedge i_sys_clk);
    chk(o_data_oe, 36'h0);
    u_sram_host.cyc(3'h2, 1'b0, 1'b1, 1'b0, 4'h0, 17'h00001, 36'h0);
    rd(1, 1'b1);
    for (int s = 0; s < 8; s++)
      if (s != 2) u_sram_host.cyc(3'(s), 1'b1, 1'b0, 1'b0, 4'h0, 17'h00002, 36'h0);
    rd(2, 1'b0);
    u_sram_host.slp = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    chk({35'h0, o_sleeping}, 36'h1);
    u_sram_host.slp = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk(o_data_oe, 36'h0);
    rd(2, 1'b1);
    u_sram_host.oe_n = 1'b1;
    u_sram_host.cyc(3'h2, 1'b1, 1'b0, 1'b1, 4'hF, 17'h00003, 36'h0);
    repeat (6) @(negedge i_sys_clk);
    chk(o_data_oe, 36'h0);
    wr(3, 1'b0, 4'hF);
    u_sram_host.oe_n = 1'b0;
    rd(3, 1'b0);
    conclude;
  end
  // Hang guard, well above the fewer than two hundred cycles the run needs
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude;
    end
  end
endmodule // test_sync_sram_select_write_sleep
